// ==== rtl/rtcb_cfg.svh ====
`ifndef RTCB_CFG_SVH
`define RTCB_CFG_SVH
// ==========================================================
// Operation
// - counter runs only while the enable bit is one
// - bit 7 keeps the counter running in standby sleep
// - prescale field divides counter clock by two to its value
// - control write takes effect two counter-clock edges later
// - status bit 3 shows match value still in transfer
// - status bit 2 shows wrap limit still in transfer
// - status bit 1 shows count value still in transfer
// - status bit 0 shows control write still in transfer
// - irq enable bit 1 enables the match interrupt
// - irq enable bit 0 enables the wrap interrupt
// - match flag sets on count equal match value, enabled or not
// - wrap flag sets when counter passes the limit back to zero
// - writing one clears a flag, writing zero leaves it
// - at the wrap limit the next increment gives zero
// - one shared temporary byte gives atomic 16-bit access
// - the temporary byte is also an ordinary read-write register
// - interrupt stands while flag and enable are both set
// - two-bit source field picks one of four counter clocks
// - tick timer interval 4 to 32768 edges, codes 0 and 15 off
// ==========================================================
// register offsets
`define RTCB_A_CTRL 5'h00
`define RTCB_A_STATUS 5'h01
`define RTCB_A_IEN 5'h02
`define RTCB_A_FLAGS 5'h03
`define RTCB_A_TEMP 5'h04
`define RTCB_A_DBG 5'h05
`define RTCB_A_SOURCE_CLOCK_SELECT 5'h07
`define RTCB_A_CNTL 5'h08
`define RTCB_A_CNTH 5'h09
`define RTCB_A_PERL 5'h0a
`define RTCB_A_PERH 5'h0b
`define RTCB_A_CMPL 5'h0c
`define RTCB_A_CMPH 5'h0d
`define RTCB_A_PITCTRL 5'h10
`define RTCB_A_PITSTAT 5'h11
`define RTCB_A_PITIEN 5'h12
`define RTCB_A_PITFLAGS 5'h13
`define RTCB_A_PITDBG 5'h15
// ==========================================================
// field masks and positions
`define RTCB_CTRL_MASK 8'hf9
`define RTCB_PITCTRL_MASK 8'h79
`define RTCB_B_WRAP 0
`define RTCB_B_MATCH 1
`define RTCB_B_TICK_TIMER_ENABLE 0
// ==========================================================
// reset values and timing
`define RTCB_RST_CTRL 8'h00
`define RTCB_RST_CNT 16'h0000
`define RTCB_RST_PER 16'hffff
`define RTCB_RST_CMP 16'h0000
`define RTCB_SYNC_EDGES 2'h2
`endif

// ==== rtl/rtcb_pkg.sv ====
package rtcb_pkg;
  typedef struct packed {
    logic keep_running_in_standby;
    logic [3:0] prescale;
    logic [1:0] spare;
    logic counter_enable_bit;
  } rtcb_ctrl_type;
  typedef struct packed {
    logic match_event;
    logic wrap_event;
  } rtcb_evt_type;
endpackage

// ==== rtl/rtcb_sync.sv ====
module rtcb_sync (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // level from another domain
  input wire logic din,
  // synchronised level
  output logic dout
);
  logic meta;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      meta <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // rtcb_sync

// ==== rtl/rtcb_top.sv ====
// Local design decision: the plain strobed port.
`include "rtcb_cfg.svh"

module rtcb_top #(
  parameter int NUM_SRC = 4
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // register port
  input wire logic [4:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WRITE,
  input wire logic READ,
  output logic [7:0] RDATA,
  // counter clock sources and sleep state
  input wire logic [NUM_SRC-1:0] SRC_CLK,
  input wire logic STANDBY,
  input wire logic DEBUG_HALT,
  // requests and events
  output logic RTC_IRQ,
  output logic PIT_IRQ,
  output logic MATCH_EVENT,
  output logic WRAP_EVENT
);
  localparam int NSYNC = 5;

  rtcb_pkg::rtcb_ctrl_type ctrl;
  rtcb_pkg::rtcb_ctrl_type ctrl_act;
  rtcb_pkg::rtcb_evt_type evt;
  logic [1:0] irq_en;
  logic [1:0] flags;
  logic [7:0] temp;
  logic dbg_run;
  logic [1:0] clk_sel;
  logic [15:0] cnt;
  logic [15:0] cnt_stage;
  logic [15:0] per_sw;
  logic [15:0] per_act;
  logic [15:0] cmp_sw;
  logic [15:0] cmp_act;
  logic [7:0] pit_ctrl;
  logic [7:0] pit_act;
  logic pit_ien;
  logic pit_flag;
  logic pit_dbg;
  logic [14:0] presc_cnt;
  logic [14:0] pit_cnt;
  logic [NUM_SRC-1:0] src_sync;
  logic rtc_prev;
  logic [NSYNC-1:0] sync_start;
  logic [NSYNC-1:0] busy;
  logic [NSYNC-1:0] sync_done;

  // ==========================================================
  // counter clock sources
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++)
    begin : g_src
      rtcb_sync u_sync (
        .clock(CLOCK),
        .rst(RST),
        .din(SRC_CLK[gi]),
        .dout(src_sync[gi])
      );
    end
  endgenerate

  // a source switch may give one stray edge
  wire sel_level = src_sync[clk_sel];
  wire rtc_edge = sel_level & ~rtc_prev;

  // ==========================================================
  // address decode
  wire wr_ctrl = WRITE && (ADDR == `RTCB_A_CTRL);
  wire wr_ien = WRITE && (ADDR == `RTCB_A_IEN);
  wire wr_flags = WRITE && (ADDR == `RTCB_A_FLAGS);
  wire wr_dbg = WRITE && (ADDR == `RTCB_A_DBG);
  wire wr_source_clock_select = WRITE && (ADDR == `RTCB_A_SOURCE_CLOCK_SELECT);
  wire wr_cnt_h = WRITE && (ADDR == `RTCB_A_CNTH);
  wire wr_per_h = WRITE && (ADDR == `RTCB_A_PERH);
  wire wr_cmp_h = WRITE && (ADDR == `RTCB_A_CMPH);
  wire wr_pitctrl = WRITE && (ADDR == `RTCB_A_PITCTRL);
  wire wr_pitien = WRITE && (ADDR == `RTCB_A_PITIEN);
  wire wr_pitflags = WRITE && (ADDR == `RTCB_A_PITFLAGS);
  wire wr_pitdbg = WRITE && (ADDR == `RTCB_A_PITDBG);
  wire wr_low = WRITE && ((ADDR == `RTCB_A_TEMP) || (ADDR == `RTCB_A_CNTL)
    || (ADDR == `RTCB_A_PERL) || (ADDR == `RTCB_A_CMPL));
  wire rd_cnt_l = READ && (ADDR == `RTCB_A_CNTL);
  wire rd_per_l = READ && (ADDR == `RTCB_A_PERL);
  wire rd_cmp_l = READ && (ADDR == `RTCB_A_CMPL);

  // low byte parks in temp, high byte reads come from temp
  wire [7:0] next_temp = wr_low ? WDATA :
    rd_cnt_l ? cnt[15:8] :
    rd_per_l ? per_sw[15:8] :
    rd_cmp_l ? cmp_sw[15:8] :
    temp;
  wire [15:0] wide_wdata = {WDATA, temp};

  // ==========================================================
  // read selection, unmapped and spare bits read zero
  wire [7:0] rd_mux =
    (ADDR == `RTCB_A_CTRL) ? ctrl :
    (ADDR == `RTCB_A_STATUS) ? {4'h0, busy[3:0]} :
    (ADDR == `RTCB_A_IEN) ? {6'h00, irq_en} :
    (ADDR == `RTCB_A_FLAGS) ? {6'h00, flags} :
    (ADDR == `RTCB_A_TEMP) ? temp :
    (ADDR == `RTCB_A_DBG) ? {7'h00, dbg_run} :
    (ADDR == `RTCB_A_SOURCE_CLOCK_SELECT) ? {6'h00, clk_sel} :
    (ADDR == `RTCB_A_CNTL) ? cnt[7:0] :
    (ADDR == `RTCB_A_CNTH) ? temp :
    (ADDR == `RTCB_A_PERL) ? per_sw[7:0] :
    (ADDR == `RTCB_A_PERH) ? temp :
    (ADDR == `RTCB_A_CMPL) ? cmp_sw[7:0] :
    (ADDR == `RTCB_A_CMPH) ? temp :
    (ADDR == `RTCB_A_PITCTRL) ? pit_ctrl :
    (ADDR == `RTCB_A_PITSTAT) ? {7'h00, busy[4]} :
    (ADDR == `RTCB_A_PITIEN) ? {7'h00, pit_ien} :
    (ADDR == `RTCB_A_PITFLAGS) ? {7'h00, pit_flag} :
    (ADDR == `RTCB_A_PITDBG) ? {7'h00, pit_dbg} :
    8'h00;

  // ==========================================================
  // transfers into the counter clock side
  assign sync_start = {wr_pitctrl, wr_cmp_h, wr_per_h, wr_cnt_h, wr_ctrl};

  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_xfer
      logic busy_q;
      logic [1:0] age;
      assign busy[gi] = busy_q;
      // done on the second edge after the write
      assign sync_done[gi] = busy_q && rtc_edge
        && (age == (`RTCB_SYNC_EDGES - 2'h1));
      always_ff @(posedge CLOCK or posedge RST)
      begin
        if (RST)
        begin
          busy_q <= 1'b0;
          age <= 2'h0;
        end
        else if (sync_start[gi])
        begin
          busy_q <= 1'b1;
          age <= 2'h0;
        end
        else if (busy_q && rtc_edge)
        begin
          busy_q <= ~sync_done[gi];
          age <= age + 2'h1;
        end
      end
    end
  endgenerate

  // ==========================================================
  // counting
  wire run = ctrl_act.counter_enable_bit
    && !(STANDBY && !ctrl_act.keep_running_in_standby)
    && !(DEBUG_HALT && !dbg_run);
  wire [14:0] presc_mask = 15'((16'h0001 << ctrl_act.prescale) - 16'h0001);
  wire tick = rtc_edge && run && ((presc_cnt & presc_mask) == presc_mask);
  wire at_top = (cnt == per_act);
  wire [15:0] next_cnt = at_top ? 16'h0000 : cnt + 16'h0001;
  assign evt.wrap_event = tick && at_top;
  assign evt.match_event = tick && (next_cnt == cmp_act);
  wire [1:0] flag_clr = wr_flags ? WDATA[1:0] : 2'h0;

  // ==========================================================
  // tick timer
  wire [3:0] pit_per = pit_act[6:3];
  wire pit_on = pit_act[`RTCB_B_TICK_TIMER_ENABLE] && (pit_per != 4'h0) && (pit_per != 4'hf)
    && !(DEBUG_HALT && !pit_dbg);
  wire [14:0] pit_mask = 15'((16'h0002 << pit_per) - 16'h0001);
  wire pit_evt = rtc_edge && pit_on && ((pit_cnt & pit_mask) == pit_mask);

  // ==========================================================
  // software registers
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      ctrl <= `RTCB_RST_CTRL;
      irq_en <= 2'h0;
      dbg_run <= 1'b0;
      clk_sel <= 2'h0;
      temp <= 8'h00;
      cnt_stage <= `RTCB_RST_CNT;
      per_sw <= `RTCB_RST_PER;
      cmp_sw <= `RTCB_RST_CMP;
      pit_ctrl <= 8'h00;
      pit_ien <= 1'b0;
      pit_dbg <= 1'b0;
      RDATA <= 8'h00;
    end
    else
    begin
      // software must wait for busy to clear before rewriting
      if (wr_ctrl)
        ctrl <= WDATA & `RTCB_CTRL_MASK;
      if (wr_ien)
        irq_en <= WDATA[1:0];
      if (wr_dbg)
        dbg_run <= WDATA[0];
      if (wr_source_clock_select)
        clk_sel <= WDATA[1:0];
      temp <= next_temp;
      if (wr_cnt_h)
        cnt_stage <= wide_wdata;
      if (wr_per_h)
        per_sw <= wide_wdata;
      if (wr_cmp_h)
        cmp_sw <= wide_wdata;
      if (wr_pitctrl)
        pit_ctrl <= WDATA & `RTCB_PITCTRL_MASK;
      if (wr_pitien)
        pit_ien <= WDATA[0];
      if (wr_pitdbg)
        pit_dbg <= WDATA[0];
      RDATA <= READ ? rd_mux : 8'h00;
    end
  end

  // ==========================================================
  // counter side state
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      rtc_prev <= 1'b0;
      ctrl_act <= `RTCB_RST_CTRL;
      per_act <= `RTCB_RST_PER;
      cmp_act <= `RTCB_RST_CMP;
      pit_act <= 8'h00;
      cnt <= `RTCB_RST_CNT;
      presc_cnt <= 15'h0000;
      pit_cnt <= 15'h0000;
    end
    else
    begin
      rtc_prev <= sel_level;
      if (sync_done[0])
        ctrl_act <= ctrl;
      if (sync_done[2])
        per_act <= per_sw;
      if (sync_done[3])
        cmp_act <= cmp_sw;
      if (sync_done[4])
        pit_act <= pit_ctrl;
      // a count load wins over a tick in the same cycle
      if (sync_done[1])
        cnt <= cnt_stage;
      else if (tick)
        cnt <= next_cnt;
      if (!ctrl_act.counter_enable_bit)
        presc_cnt <= 15'h0000;
      else if (rtc_edge && run)
        presc_cnt <= presc_cnt + 15'h0001;
      if (!pit_on)
        pit_cnt <= 15'h0000;
      else if (rtc_edge)
        pit_cnt <= pit_cnt + 15'h0001;
    end
  end

  // ==========================================================
  // flags and requests, a new event beats a clear
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      flags <= 2'h0;
      pit_flag <= 1'b0;
      MATCH_EVENT <= 1'b0;
      WRAP_EVENT <= 1'b0;
    end
    else
    begin
      flags <= (flags & ~flag_clr) | evt;
      pit_flag <= (pit_flag & ~(wr_pitflags && WDATA[0])) | pit_evt;
      MATCH_EVENT <= evt.match_event;
      WRAP_EVENT <= evt.wrap_event;
    end
  end

  assign RTC_IRQ = |(flags & irq_en);
  assign PIT_IRQ = pit_flag && pit_ien;

  // ==========================================================
  // checks
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  property p_stop_holds;
    !ctrl_act.counter_enable_bit && !sync_done[1] |=> cnt == $past(cnt);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("count moved while off");
  property p_standby;
    STANDBY && !ctrl_act.keep_running_in_standby |-> !tick;
  endproperty
  a_standby: assert property (p_standby) else $error("tick in standby");
  property p_presc;
    tick && (ctrl_act.prescale != 4'h0) |-> presc_cnt[0] && rtc_edge;
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler tick early");
  property p_ctrl_apply;
    $changed(ctrl_act) |-> $past(busy[0]) && $past(rtc_edge) && !busy[0];
  endproperty
  a_ctrl_apply: assert property (p_ctrl_apply) else $error("control applied early");
  property p_ctrl_busy;
    wr_ctrl |=> busy[0] && !$changed(ctrl_act);
  endproperty
  a_ctrl_busy: assert property (p_ctrl_busy) else $error("control busy missing");
  property p_cmp_busy;
    wr_cmp_h |=> busy[3] && (cmp_sw == $past(wide_wdata));
  endproperty
  a_cmp_busy: assert property (p_cmp_busy) else $error("match busy missing");
  property p_per_busy;
    wr_per_h |=> busy[2] && (per_sw == $past(wide_wdata));
  endproperty
  a_per_busy: assert property (p_per_busy) else $error("limit busy missing");
  property p_cnt_busy;
    wr_cnt_h ##1 !rtc_edge |=> busy[1];
  endproperty
  a_cnt_busy: assert property (p_cnt_busy) else $error("count busy dropped");
  property p_match_flag;
    evt.match_event |=> flags[`RTCB_B_MATCH] && MATCH_EVENT;
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match flag missing");

  property p_wrap;
    tick && at_top && !sync_done[1] |=> cnt == 16'h0000 && flags[`RTCB_B_WRAP];
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap not to zero");

  property p_incr;
    tick && !at_top && !sync_done[1] |=> cnt == $past(cnt) + 16'h0001;
  endproperty
  a_incr: assert property (p_incr) else $error("count not incremented");

  property p_w1c;
    wr_flags && WDATA[`RTCB_B_MATCH] && !evt.match_event |=> !flags[`RTCB_B_MATCH];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");

  property p_irq;
    (flags[`RTCB_B_MATCH] && irq_en[`RTCB_B_MATCH]) |-> RTC_IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("request missing");

  property p_temp_read;
    rd_cnt_l |=> {temp, 8'h00} == ($past(cnt) & 16'hff00);
  endproperty
  a_temp_read: assert property (p_temp_read) else $error("high byte not parked");

  property p_unmapped;
    READ && (ADDR == 5'h06) |=> RDATA == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("reserved read not zero");

  c_wrap: cover property (evt.wrap_event);
  c_match_irq: cover property (evt.match_event && irq_en[`RTCB_B_MATCH]);
  c_ctrl_sync: cover property (wr_ctrl ##[1:20] sync_done[0]);
  c_pit: cover property (pit_evt);
endmodule // rtcb_top

// ==== dv/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // stimulus and observed signals
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic [4:0] ADDR = 5'h00;
  logic [7:0] WDATA = 8'h00;
  logic WRITE = 1'b0;
  logic READ = 1'b0;
  logic [7:0] RDATA;
  logic [3:0] SRC_CLK = 4'h0;
  logic STANDBY = 1'b0;
  logic DEBUG_HALT = 1'b0;
  logic RTC_IRQ;
  logic PIT_IRQ;
  logic MATCH_EVENT;
  logic WRAP_EVENT;
  int mismatches = 0;
  int n_compared = 0;
  logic [15:0] v;
  logic [15:0] a;
  int n_match_evt = 0;
  int n_wrap_evt = 0;

  rtcb_top uut (
    .CLOCK(CLOCK),
    .RST(RST),
    .ADDR(ADDR),
    .WDATA(WDATA),
    .WRITE(WRITE),
    .READ(READ),
    .RDATA(RDATA),
    .SRC_CLK(SRC_CLK),
    .STANDBY(STANDBY),
    .DEBUG_HALT(DEBUG_HALT),
    .RTC_IRQ(RTC_IRQ),
    .PIT_IRQ(PIT_IRQ),
    .MATCH_EVENT(MATCH_EVENT),
    .WRAP_EVENT(WRAP_EVENT)
  );

  always #25 CLOCK = ~CLOCK;

  // events are one-cycle pulses, so count them as they pass
  always @(posedge CLOCK)
  begin
    if (MATCH_EVENT === 1'b1)
      n_match_evt++;
    if (WRAP_EVENT === 1'b1)
      n_wrap_evt++;
  end

  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] ad, input logic [7:0] d);
    @(posedge CLOCK);
    ADDR <= ad;
    WDATA <= d;
    WRITE <= 1'b1;
    @(posedge CLOCK);
    WRITE <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] ad, output logic [7:0] d);
    @(posedge CLOCK);
    ADDR <= ad;
    READ <= 1'b1;
    @(posedge CLOCK);
    READ <= 1'b0;
    #1 d = RDATA;
  endtask

  // low byte first: it parks in the shared temp until the high byte write
  task automatic wr16(input logic [4:0] ad, input logic [15:0] d);
    wr(ad, d[7:0]);
    wr(ad + 5'h01, d[15:8]);
  endtask

  task automatic rd16(input logic [4:0] ad, output logic [15:0] d);
    rd(ad, d[7:0]);
    rd(ad + 5'h01, d[15:8]);
  endtask

  // one counter edge: slow enough for the two-flop synchroniser
  task automatic edges(input int s, input int n);
    repeat (n)
    begin
      @(posedge CLOCK);
      SRC_CLK <= 4'(4'h1 << s);
      repeat (4) @(posedge CLOCK);
      SRC_CLK <= 4'h0;
      repeat (4) @(posedge CLOCK);
    end
  endtask

  task automatic rdchk(input string what, input logic [4:0] ad, input logic [7:0] exp);
    logic [7:0] d;
    rd(ad, d);
    check(what, {8'h00, exp}, {8'h00, d});
  endtask

  // ==========================================================
  // scenarios
  task automatic test_regs;
    for (int i = 0; i < 8; i++)
      rdchk("reset byte", i[4:0], 8'h00);
    rd16(5'h0a, v);
    check("reset limit", 16'hffff, v);
    wr(5'h04, 8'ha5);
    rdchk("temp", 5'h04, 8'ha5);
    wr(5'h02, 8'hff);
    rdchk("irq enable bits", 5'h02, 8'h03);
    wr(5'h02, 8'h00);
    wr(5'h0e, 8'hff);
    rdchk("unmapped", 5'h0e, 8'h00);
    $display("test regs done");
  endtask

  task automatic test_count;
    rdchk("idle", 5'h01, 8'h00);
    wr16(5'h0a, 16'h0003);
    wr16(5'h0c, 16'h0002);
    wr16(5'h08, 16'h0000);
    wr(5'h00, 8'h01);
    rdchk("all busy", 5'h01, 8'h0f);
    edges(0, 1);
    rdchk("busy one edge", 5'h01, 8'h0f);
    edges(0, 1);
    rdchk("busy clear", 5'h01, 8'h00);
    rd16(5'h08, v);
    check("count start", 16'h0000, v);
    for (int i = 1; i < 5; i++)
    begin
      edges(0, 1);
      rd16(5'h08, v);
      check("count", 16'(i % 4), v);
      if (i == 2)
        rdchk("match flag", 5'h03, 8'h02);
    end
    rdchk("both flags", 5'h03, 8'h03);
    check("match events", 16'h0001, 16'(n_match_evt));
    check("wrap events", 16'h0001, 16'(n_wrap_evt));
    check("irq off", 16'h0000, {15'h0, RTC_IRQ});
    wr(5'h02, 8'h01);
    #1 check("wrap irq", 16'h0001, {15'h0, RTC_IRQ});
    wr(5'h03, 8'h02);
    rdchk("w1c one", 5'h03, 8'h01);
    check("irq stays", 16'h0001, {15'h0, RTC_IRQ});
    wr(5'h02, 8'h02);
    #1 check("match irq idle", 16'h0000, {15'h0, RTC_IRQ});
    wr(5'h03, 8'h01);
    edges(0, 2);
    #1 check("match irq", 16'h0001, {15'h0, RTC_IRQ});
    check("match events again", 16'h0002, 16'(n_match_evt));
    wr(5'h03, 8'h03);
    rdchk("flags clear", 5'h03, 8'h00);
    check("irq clear", 16'h0000, {15'h0, RTC_IRQ});
    wr(5'h02, 8'h00);
    $display("test count done");
  endtask

  task automatic test_prescale;
    // software waits for busy to clear before rewriting control
    wr(5'h00, 8'h08);
    wr16(5'h0a, 16'hffff);
    edges(0, 3);
    rd16(5'h08, a);
    edges(0, 2);
    rd16(5'h08, v);
    check("stopped", a, v);
    wr(5'h00, 8'h09);
    edges(0, 3);
    rd16(5'h08, a);
    edges(0, 4);
    rd16(5'h08, v);
    check("div two", 16'(a + 16'h0002), v);
    STANDBY <= 1'b1;
    rd16(5'h08, a);
    edges(0, 4);
    rd16(5'h08, v);
    check("standby stop", a, v);
    wr(5'h00, 8'h89);
    edges(0, 3);
    rd16(5'h08, a);
    edges(0, 4);
    rd16(5'h08, v);
    check("standby run", 16'(a + 16'h0002), v);
    STANDBY <= 1'b0;
    $display("test prescale done");
  endtask

  // interval code 1 gives one tick event per four counter edges
  task automatic test_pit;
    wr(5'h12, 8'h01);
    wr(5'h10, 8'h09);
    rdchk("tick busy", 5'h11, 8'h01);
    edges(0, 2);
    rdchk("tick busy clear", 5'h11, 8'h00);
    rdchk("tick control", 5'h10, 8'h09);
    edges(0, 3);
    check("tick idle", 16'h0000, {15'h0, PIT_IRQ});
    edges(0, 1);
    check("tick irq", 16'h0001, {15'h0, PIT_IRQ});
    rdchk("tick flag", 5'h13, 8'h01);
    wr(5'h13, 8'h01);
    #1 check("tick clear", 16'h0000, {15'h0, PIT_IRQ});
    wr(5'h10, 8'h00);
    $display("test pit done");
  endtask

  task automatic test_source;
    wr(5'h00, 8'h01);
    edges(0, 3);
    for (int s = 0; s < 4; s++)
    begin
      wr(5'h07, s[7:0]);
      rdchk("source field", 5'h07, s[7:0]);
      // a switch may give one stray edge, so take the base after it
      repeat (8) @(posedge CLOCK);
      rd16(5'h08, a);
      edges((s + 1) % 4, 2);
      edges(s, 2);
      rd16(5'h08, v);
      check("source count", 16'(a + 16'h0002), v);
    end
    DEBUG_HALT <= 1'b1;
    rd16(5'h08, a);
    edges(3, 2);
    rd16(5'h08, v);
    check("halt stop", a, v);
    wr(5'h05, 8'h01);
    rdchk("halt run bit", 5'h05, 8'h01);
    rd16(5'h08, a);
    edges(3, 2);
    rd16(5'h08, v);
    check("halt run", 16'(a + 16'h0002), v);
    DEBUG_HALT <= 1'b0;
    $display("test source done");
  endtask

  // ==========================================================
  // verdict
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // whole run is under a thousand cycles
  initial
  begin
    repeat (40000) @(posedge CLOCK);
    mismatches++;
    finish_test();
  end

  initial
  begin
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    test_regs();
    test_count();
    test_prescale();
    test_pit();
    test_source();
    finish_test();
  end
endmodule // testbench
